// >>> inc/lcfu_pkg.sv
package lcfu_pkg;

    typedef enum logic [4:0]
    {
        LCFU_LOGIC = 5'h01,
        LCFU_HALF = 5'h02,
        LCFU_RIPPLE = 5'h04,
        LCFU_RAM = 5'h08,
        LCFU_ROM = 5'h10
    } lcfu_mode_t;

    typedef struct packed
    {
        logic sel;
        logic add_sub_write_enable;
        logic local_set_reset;
        logic ce;
        logic clk;
    } lcfu_ctl_t;

    localparam int CTL_CLK = 0;
    localparam int CTL_CE = 1;
    localparam int CTL_LSR = 2;
    localparam int CTL_ADD_SUB_WRITE_ENABLE = 3;
    localparam int CTL_SEL = 4;
    localparam logic [4:0] CTL_DFLT = 5'h0b;

    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_ROUTE = 12'h004;
    localparam logic [11:0] ADDR_SWL = 12'h008;
    localparam logic [11:0] ADDR_STAT = 12'h00c;
    localparam logic [6:0] LUT_PAGE = 7'h01;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_EN_LSB = 5;
    localparam int CTRL_INV_LSB = 10;
    localparam int CTRL_ASYNC = 15;
    localparam int CTRL_SETV_LSB = 16;
    localparam int CTRL_CEG_LSB = 25;
    localparam int CTRL_LSRG_LSB = 28;
    localparam int ROUTE_F5_LSB = 0;
    localparam int ROUTE_NINTH_RIP = 4;
    localparam int ROUTE_ROM_SYNC = 5;
    localparam int ROUTE_ASWEG_LSB = 6;
    localparam int ROUTE_W = 9;

    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [8:0] ROUTE_RST = 9'h000;
    localparam logic [31:0] SWL_RST = 32'h0000_0000;
    localparam logic [15:0] LUT_RST = 16'h0000;

    typedef struct packed
    {
        logic [31:0] ctrl;
        logic [ROUTE_W-1:0] route;
        logic [31:0] softwired_table;
        logic [7:0][15:0] lut;
        logic [7:0] q;
        logic q9;
        logic [31:0] rdata;
    } lcfu_state_t;

endpackage

// >>> src/lcfu_unit.sv
`timescale 1ns/1ns
// Functional notes
// - Global active-low set/reset forces every storage element.
// - Local set/reset sync or async, value per element.
// - Select input picks direct data or table outputs.
// - Every control input can be disabled or inverted.
// - Disabled clock enable means always enabled.
// - Disabled local set/reset never sets or clears.
// - Disabled select routes direct data to storage outside RAM and ROM modes.
// - Per-nibble and ninth enables for reset, enable.
// - Logic mode: add/subtract input as extra enable.
// - Ripple, half modes: add/subtract drives ripple control.
// - RAM: write enable, port enables from controls.
// - ROM: synchronous outputs register every cycle, clock input unused.
// - Table output direct, registered, or multiplexed.
// - Only pairs 0/1..6/7 mux, onto even output.
// - Fifth input selects table for 0 or 1.
// - Any mix of four- and five-input tables.
// - Tables can feed other tables internally.
// - Fed-back outputs stay available for output, storage.
// - Half mode: upper nibble logic, lower nibble ripple.
// - Half mode ninth flip-flop general or carry register.
// - Ninth flip-flop takes carry input, drives carry out.
module lcfu_unit
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire global_set_reset_n,
    input lcfu_pkg::lcfu_ctl_t controls,
    input wire [7:0][3:0] table_inputs,
    input wire [3:0] fifth_input_selects,
    input wire [7:0] din,
    input wire carry_in,
    input wire ripple_carry,
    output logic [7:0] comb_out,
    output logic [7:0] reg_out,
    output logic registered_carry_out,
    output logic ripple_control
);

    lcfu_pkg::lcfu_state_t st_q;
    lcfu_pkg::lcfu_state_t st_d;
    logic [4:0] raw;
    logic [4:0] c;
    logic [4:0] en;
    logic [4:0] inv;
    logic is_logic;
    logic is_half;
    logic is_rip;
    logic is_ram;
    logic is_rom;
    logic mem;
    logic lsr_async;
    logic [8:0] setv;
    logic [2:0] grp_ce;
    logic [2:0] grp_lsr;
    logic [2:0] force_g;
    logic [2:0] cap;
    logic [7:0] lut_out;
    logic [7:0] d_in;
    logic ninth_d;
    logic mem_cap;
    logic ram_we;
    logic mapped;
    logic [31:0] rd_val;

    function automatic logic is_lut(input logic [11:0] a);
        return a[11:5] == lcfu_pkg::LUT_PAGE && a[1:0] == 2'h0;
    endfunction

    assign raw = controls;
    assign en = st_q.ctrl[lcfu_pkg::CTRL_EN_LSB +: 5];
    assign inv = st_q.ctrl[lcfu_pkg::CTRL_INV_LSB +: 5];
    assign lsr_async = st_q.ctrl[lcfu_pkg::CTRL_ASYNC];
    assign setv = st_q.ctrl[lcfu_pkg::CTRL_SETV_LSB +: 9];

    // A disabled control falls back to its neutral level.
    for (genvar i = 0; i < 5; i++)
    begin : g_ctl
        assign c[i] = en[i] ? raw[i] ^ inv[i] : lcfu_pkg::CTL_DFLT[i];
    end

    // Unknown mode codes fall back to logic mode so storage stays usable.
    always_comb
    begin
        is_logic = 1'b0;
        is_half = 1'b0;
        is_rip = 1'b0;
        is_ram = 1'b0;
        is_rom = 1'b0;
        unique case (st_q.ctrl[lcfu_pkg::CTRL_MODE_LSB +: 5])
            lcfu_pkg::LCFU_LOGIC: is_logic = 1'b1;
            lcfu_pkg::LCFU_HALF: is_half = 1'b1;
            lcfu_pkg::LCFU_RIPPLE: is_rip = 1'b1;
            lcfu_pkg::LCFU_RAM: is_ram = 1'b1;
            lcfu_pkg::LCFU_ROM: is_rom = 1'b1;
            default: is_logic = 1'b1;
        endcase
    end

    assign mem = is_ram | is_rom;

    for (genvar g = 0; g < 3; g++)
    begin : g_grp
        assign grp_ce[g] = (~st_q.ctrl[lcfu_pkg::CTRL_CEG_LSB + g] | c[lcfu_pkg::CTL_CE])
            & (~(is_logic & st_q.route[lcfu_pkg::ROUTE_ASWEG_LSB + g])
            | c[lcfu_pkg::CTL_ADD_SUB_WRITE_ENABLE]);
        assign grp_lsr[g] = st_q.ctrl[lcfu_pkg::CTRL_LSRG_LSB + g] & c[lcfu_pkg::CTL_LSR]
            & ~mem;
        assign force_g[g] = ~global_set_reset_n | (grp_lsr[g] & lsr_async);
        assign cap[g] = c[lcfu_pkg::CTL_CLK] & grp_ce[g] & ~mem;
    end

    // Feedback may only come from a lower-numbered table, which keeps the
    // network free of combinational loops while still allowing chains through all eight tables.
    always_comb
    begin
        logic [3:0] a;
        logic ok;
        a = 4'h0;
        ok = 1'b0;
        lut_out = 8'h00;
        for (int k = 0; k < 8; k++)
        begin
            a = table_inputs[k];
            ok = st_q.softwired_table[k*4+3] && (st_q.softwired_table[k*4 +: 3] < 3'(k))
                && (is_logic || (is_half && k >= 4));
            if (ok)
            begin
                a[0] = lut_out[st_q.softwired_table[k*4 +: 3]];
            end
            lut_out[k] = st_q.lut[k][a];
        end
    end

    for (genvar p = 0; p < 4; p++)
    begin : g_f5
        logic f5_ok;
        assign f5_ok = st_q.route[lcfu_pkg::ROUTE_F5_LSB + p]
            & (is_logic | (is_half & (p >= 2)));
        assign comb_out[2*p] = (f5_ok & fifth_input_selects[p]) ? lut_out[2*p+1]
            : lut_out[2*p];
        assign comb_out[2*p+1] = lut_out[2*p+1];
    end

    assign d_in = (c[lcfu_pkg::CTL_SEL] | mem) ? comb_out : din;
    assign ninth_d = (is_rip | (is_half & st_q.route[lcfu_pkg::ROUTE_NINTH_RIP]))
        ? ripple_carry : carry_in;
    assign mem_cap = is_ram ? c[lcfu_pkg::CTL_LSR] & c[lcfu_pkg::CTL_CLK]
        : is_rom & st_q.route[lcfu_pkg::ROUTE_ROM_SYNC];
    assign ram_we = is_ram & c[lcfu_pkg::CTL_ADD_SUB_WRITE_ENABLE] & c[lcfu_pkg::CTL_CE]
        & c[lcfu_pkg::CTL_CLK];
    assign ripple_control = (is_half | is_rip) & c[lcfu_pkg::CTL_ADD_SUB_WRITE_ENABLE];

    assign mapped = is_lut(paddr) || paddr == lcfu_pkg::ADDR_CTRL
        || paddr == lcfu_pkg::ADDR_ROUTE || paddr == lcfu_pkg::ADDR_SWL
        || paddr == lcfu_pkg::ADDR_STAT;

    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (is_lut(paddr))
        begin
            rd_val = {16'h0000, st_q.lut[paddr[4:2]]};
        end
        else if (paddr == lcfu_pkg::ADDR_CTRL)
        begin
            rd_val = st_q.ctrl;
        end
        else if (paddr == lcfu_pkg::ADDR_ROUTE)
        begin
            rd_val = {23'h000000, st_q.route};
        end
        else if (paddr == lcfu_pkg::ADDR_SWL)
        begin
            rd_val = st_q.softwired_table;
        end
        else if (paddr == lcfu_pkg::ADDR_STAT)
        begin
            rd_val = {22'h000000, ripple_control, registered_carry_out, reg_out};
        end
    end

    always_comb
    begin
        st_d = st_q;
        if (psel && !penable)
        begin
            st_d.rdata = rd_val;
        end
        if (psel && penable && pwrite)
        begin
            if (is_lut(paddr))
            begin
                st_d.lut[paddr[4:2]] = pwdata[15:0];
            end
            else if (paddr == lcfu_pkg::ADDR_CTRL)
            begin
                st_d.ctrl = pwdata;
            end
            else if (paddr == lcfu_pkg::ADDR_ROUTE)
            begin
                st_d.route = pwdata[lcfu_pkg::ROUTE_W-1:0];
            end
            else if (paddr == lcfu_pkg::ADDR_SWL)
            begin
                st_d.softwired_table = pwdata;
            end
        end
        // Memory writes land after the bus so a clash leaves the user's data.
        if (ram_we)
        begin
            for (int b = 0; b < 4; b++)
            begin
                st_d.lut[{fifth_input_selects[0], 2'(b)}][din[7:4]] = din[b];
            end
        end
        for (int i = 0; i < 8; i++)
        begin
            if (force_g[i/4])
            begin
                st_d.q[i] = setv[i];
            end
            else if (grp_lsr[i/4] && c[lcfu_pkg::CTL_CLK])
            begin
                st_d.q[i] = setv[i];
            end
            else if (cap[i/4] || mem_cap)
            begin
                st_d.q[i] = d_in[i];
            end
        end
        if (force_g[2])
        begin
            st_d.q9 = setv[8];
        end
        else if (grp_lsr[2] && c[lcfu_pkg::CTL_CLK])
        begin
            st_d.q9 = setv[8];
        end
        else if (cap[2])
        begin
            st_d.q9 = ninth_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q.ctrl <= lcfu_pkg::CTRL_RST;
            st_q.route <= lcfu_pkg::ROUTE_RST;
            st_q.softwired_table <= lcfu_pkg::SWL_RST;
            st_q.lut <= {8{lcfu_pkg::LUT_RST}};
            st_q.q <= 8'h00;
            st_q.q9 <= 1'b0;
            st_q.rdata <= 32'h0000_0000;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // The override path makes a set or clear visible without waiting for a clock.
    for (genvar i = 0; i < 8; i++)
    begin : g_out
        assign reg_out[i] = force_g[i/4] ? setv[i] : st_q.q[i];
    end
    assign registered_carry_out = force_g[2] ? setv[8] : st_q.q9;

    assign prdata = st_q.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_lo_capture;
        is_logic && cap[0] && !grp_lsr[0] && !force_g[0];
    endsequence

    a_apb_read_data: assert property (s_setup ##1 s_access |-> prdata == $past(rd_val))
        else $error("Read data does not match the addressed register.");
    a_global_force: assert property (!global_set_reset_n |->
        (reg_out == setv[7:0] && registered_carry_out == setv[8])
        ##1 (st_q.q == $past(setv[7:0])))
        else $error("Global set/reset did not force the storage elements.");
    a_async_local: assert property (lsr_async && grp_lsr[1] |->
        reg_out[7:4] == setv[7:4] ##1 (st_q.q[7:4] == $past(setv[7:4])))
        else $error("Asynchronous local set/reset did not override at once.");
    a_sync_local: assert property (!lsr_async && grp_lsr[0] && c[0] && global_set_reset_n
        |=> st_q.q[3:0] == $past(setv[3:0]))
        else $error("Synchronous local set/reset did not act at the edge.");
    a_lsr_disabled: assert property (!en[lcfu_pkg::CTL_LSR] |-> grp_lsr == 3'h0)
        else $error("Disabled local set/reset still reached the storage elements.");
    a_lo_capture: assert property (s_lo_capture |=> st_q.q[3:0] == $past(d_in[3:0]))
        else $error("Lower nibble did not capture its selected data.");
    a_sel_off_din: assert property (!en[lcfu_pkg::CTL_SEL] && !mem |-> d_in == din)
        else $error("Disabled select did not route direct data.");
    a_ce_hold: assert property (is_logic && !grp_ce[1] && !grp_lsr[1] && !force_g[1]
        |=> $stable(st_q.q[7:4]))
        else $error("Disabled nibble changed without enable.");
    a_add_sub_write_enable_ripple: assert property ((is_half || is_rip) |-> ripple_control
        == c[lcfu_pkg::CTL_ADD_SUB_WRITE_ENABLE])
        else $error("Add/subtract input did not reach the ripple control.");
    a_add_sub_write_enable_not_ce: assert property ((is_half || is_rip) && c[lcfu_pkg::CTL_CE]
        |-> grp_ce == 3'h7)
        else $error("Add/subtract input gated a clock outside logic mode.");
    a_f5_even: assert property (is_logic && st_q.route[0] && fifth_input_selects[0]
        |-> comb_out[0] == lut_out[1] && comb_out[1] == lut_out[1])
        else $error("Pair multiplexer did not place the odd table on the even output.");
    a_ninth_carry: assert property (is_logic && cap[2] && !grp_lsr[2] && !force_g[2]
        |=> st_q.q9 == $past(carry_in))
        else $error("Ninth flip-flop did not capture the carry input.");
    a_ninth_ripple: assert property (cap[2] && !grp_lsr[2] && !force_g[2] && (is_rip
        || (is_half && st_q.route[lcfu_pkg::ROUTE_NINTH_RIP])) |=> st_q.q9 == $past(ripple_carry))
        else $error("Ninth flip-flop did not capture the ripple carry.");
    a_rom_hold: assert property (is_rom && !st_q.route[lcfu_pkg::ROUTE_ROM_SYNC]
        && global_set_reset_n |=> $stable(st_q.q))
        else $error("Asynchronous ROM changed its storage elements.");
    a_rom_sync: assert property (is_rom && st_q.route[lcfu_pkg::ROUTE_ROM_SYNC]
        && global_set_reset_n |=> st_q.q == $past(comb_out))
        else $error("Synchronous ROM did not register the table outputs.");
    a_ram_write: assert property (is_ram && c[lcfu_pkg::CTL_ADD_SUB_WRITE_ENABLE]
        && c[lcfu_pkg::CTL_CE] && c[lcfu_pkg::CTL_CLK]
        |=> st_q.lut[{$past(fifth_input_selects[0]), 2'h0}][$past(din[7:4])] == $past(din[0]))
        else $error("Memory write did not store the data bit.");

endmodule

// >>> sim/lcfu_user_model.sv
`timescale 1ns/1ns
// User logic around the unit; it only changes its outputs just after a rising edge.
module lcfu_user_model
(
    input wire pclk,
    output lcfu_pkg::lcfu_ctl_t controls,
    output logic [7:0][3:0] table_inputs,
    output logic [3:0] fifth_input_selects,
    output logic [7:0] din,
    output logic carry_in,
    output logic ripple_carry,
    output logic global_set_reset_n
);
    initial
    begin
        controls = '0;
        table_inputs = '0;
        fifth_input_selects = '0;
        din = '0;
        carry_in = 1'b0;
        ripple_carry = 1'b1;
        global_set_reset_n = 1'b1;
    end

    task automatic put(input logic [4:0] c, input logic [31:0] t, input logic [3:0] f,
        input logic [7:0] d, input logic ci, input logic g);
        @(posedge pclk);
        controls <= c;
        table_inputs <= t;
        fifth_input_selects <= f;
        din <= d;
        carry_in <= ci;
        ripple_carry <= ~ci;
        global_set_reset_n <= g;
    endtask
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ns
module tb;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    lcfu_pkg::lcfu_ctl_t controls;
    logic [7:0][3:0] table_inputs;
    logic [3:0] fifth_input_selects;
    logic [7:0] din;
    logic carry_in;
    logic ripple_carry;
    logic global_set_reset_n;
    logic [7:0] comb_out;
    logic [7:0] reg_out;
    logic registered_carry_out;
    logic ripple_control;
    logic [7:0][15:0] lut;
    logic [31:0] rd;
    logic err;
    logic [8:0] prev;
    logic [31:0] t;
    logic [3:0] f;
    logic [7:0] d;
    logic s;
    logic [2:0] sw;
    logic [8:0] want;
    logic [31:0] tc[7];
    logic [8:0] tr[7];
    logic [4:0] tk[7];
    logic [8:0] tm[7];
    int fail_count;
    int cmp_count;

    lcfu_unit dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .global_set_reset_n, .controls, .table_inputs,
        .fifth_input_selects, .din, .carry_in, .ripple_carry, .comb_out, .reg_out,
        .registered_carry_out, .ripple_control);
    lcfu_user_model usr_u (.pclk, .controls, .table_inputs, .fifth_input_selects, .din,
        .carry_in, .ripple_carry, .global_set_reset_n);

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (fail_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 16)
        begin
            fail_count++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Drives one user cycle, notes the state before the capturing edge, then waits that edge.
    task automatic step(input logic [4:0] c, input logic g);
        usr_u.put(c, t, f, d, d[0], g);
        #1;
        prev = {registered_carry_out, reg_out};
        @(posedge pclk);
        #1;
    endtask

    function automatic logic [7:0] comb_exp(input logic [3:0] mux);
        logic [7:0] c;
        for (int k = 0; k < 8; k++)
            c[k] = lut[k][t[4*k+:4]];
        for (int p = 0; p < 4; p++)
            if (mux[p])
                c[2*p] = f[p] ? c[2*p+1] : c[2*p];
        return c;
    endfunction

    initial
    begin
        fail_count = 0;
        cmp_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        t = '0;
        f = '0;
        d = '0;
        tc = '{32'h02000041, 32'h02000041, 32'h02000841, 32'h0e000041, 32'h101, 32'h102,
            32'h102};
        tr = '{9'h0, 9'h0, 9'h0, 9'h0, 9'h080, 9'h080, 9'h080};
        tk = '{5'h00, 5'h02, 5'h02, 5'h00, 5'h00, 5'h00, 5'h08};
        tm = '{9'h00f, 9'h0, 9'h00f, 9'h1ff, 9'h0f0, 9'h0, 9'h0};
        void'($urandom(32'h67bd));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, lcfu_pkg::ADDR_CTRL, 0);
        check(rd, lcfu_pkg::CTRL_RST);
        apb(0, lcfu_pkg::ADDR_ROUTE, 0);
        check(rd, 32'(lcfu_pkg::ROUTE_RST));
        apb(0, lcfu_pkg::ADDR_SWL, 0);
        check(rd, lcfu_pkg::SWL_RST);
        apb(0, 12'h010, 0);
        check(rd, 0);
        check(err, 1);
        repeat (6)
        begin
            d = 8'($urandom);
            t = $urandom;
            step(5'($urandom), 1'b1);
            check({registered_carry_out, reg_out}, {d[0], d});
        end
        for (int k = 0; k < 8; k++)
        begin
            lut[k] = 16'($urandom);
            apb(1, 12'(12'h020 + 4 * k), {16'h0, lut[k]});
        end
        apb(0, 12'h02c, 0);
        check(rd, {16'h0, lut[3]});
        for (int m = 0; m < 2; m++)
        begin
            if (m == 1)
                apb(1, lcfu_pkg::ADDR_ROUTE, 32'hf);
            repeat (8)
            begin
                t = $urandom;
                f = 4'($urandom);
                for (int p = 0; p < 4 && m == 1; p++)
                    t[8*p+4+:4] = t[8*p+:4];
                step(5'h0, 1'b1);
                check(comb_out, comb_exp({4{m[0]}}));
            end
        end
        apb(1, lcfu_pkg::ADDR_CTRL, 32'h201);
        repeat (6)
        begin
            s = 1'($urandom);
            d = 8'($urandom);
            step({s, 4'h0}, 1'b1);
            check(reg_out, s ? comb_exp(4'hf) : d);
        end
        apb(1, lcfu_pkg::ADDR_ROUTE, 0);
        for (int i = 0; i < 7; i++)
        begin
            apb(1, lcfu_pkg::ADDR_CTRL, tc[i]);
            apb(1, lcfu_pkg::ADDR_ROUTE, 32'(tr[i]));
            d = 8'($urandom);
            step(tk[i], 1'b1);
            check({registered_carry_out, reg_out}, ({d[0], d} & ~tm[i]) | (prev & tm[i]));
            check(ripple_control, tc[i][1] & tk[i][3]);
        end
        apb(1, lcfu_pkg::ADDR_CTRL, 32'h71a50081);
        step(5'h04, 1'b1);
        check({registered_carry_out, reg_out}, 9'h1a5);
        step(5'h00, 1'b1);
        apb(1, lcfu_pkg::ADDR_CTRL, 32'h705a8081);
        usr_u.put(5'h04, t, f, d, d[0], 1'b1);
        #1;
        check({registered_carry_out, reg_out}, 9'h05a);
        apb(1, lcfu_pkg::ADDR_CTRL, 32'h015a0001);
        usr_u.put(5'h00, t, f, d, d[0], 1'b0);
        #1;
        check({registered_carry_out, reg_out}, 9'h15a);
        d = ~d;
        step(5'h02, 1'b0);
        check({registered_carry_out, reg_out}, 9'h15a);
        // The write data and address must already stand when memory mode starts.
        d = 8'($urandom);
        f = 4'h0;
        step(5'h0, 1'b1);
        apb(1, lcfu_pkg::ADDR_CTRL, 32'h8);
        apb(1, lcfu_pkg::ADDR_CTRL, 32'h1);
        for (int b = 0; b < 4; b++)
        begin
            lut[b][d[7:4]] = d[b];
            apb(0, 12'(12'h020 + 4 * b), 0);
            check(rd, {16'h0, lut[b]});
        end
        for (int j = 0; j < 3; j++)
        begin
            apb(1, lcfu_pkg::ADDR_ROUTE, (j == 1) ? 32'h010 : 32'h1c0);
            apb(1, lcfu_pkg::ADDR_CTRL, (j == 0) ? 32'h104 : 32'h102);
            d = 8'($urandom);
            s = 1'($urandom);
            step({1'b0, s, 3'h0}, 1'b1);
            check({registered_carry_out, reg_out}, {d[0] ^ (j < 2), d});
            check(ripple_control, s);
        end
        apb(1, lcfu_pkg::ADDR_CTRL, 32'h7fff83f0);
        for (int j = 0; j < 2; j++)
        begin
            apb(1, lcfu_pkg::ADDR_ROUTE, (j == 0) ? 32'h020 : 32'h000);
            t = $urandom;
            d = 8'($urandom);
            step(5'h1d, 1'b1);
            want = (j == 0) ? {prev[8], comb_exp(4'h0)} : prev;
            check({registered_carry_out, reg_out}, want);
        end
        apb(1, lcfu_pkg::ADDR_CTRL, 32'h1);
        apb(1, lcfu_pkg::ADDR_SWL, 32'h980);
        repeat (4)
        begin
            t = $urandom;
            step(5'h0, 1'b1);
            sw[0] = lut[0][t[3:0]];
            sw[1] = lut[1][{t[7:5], sw[0]}];
            sw[2] = lut[2][{t[11:9], sw[1]}];
            check(comb_out[2:0], sw);
        end
        apb(0, lcfu_pkg::ADDR_STAT, 0);
        check(rd, {23'h0, d[0], d});
        check(err, 0);
        results();
    end
endmodule
